//--- src/scpr_regs.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "scpr_defs.svh"


module scpr_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             sync_ref_coupling_select,
   output logic             sync_ref_receiver_off,
   output logic      [2:0]  nv_seq_field_a,
   output logic             nv_seq_bit_b,
   output logic             nv_seq_bit_c,
   output logic      [4:0]  obs_clock_swing_code,
   output logic             obs_clock_inverted,
   output logic             obs_clock_driver_off,
   output logic             converter0_off,
   output logic             converter1_off,
   output logic             analog_clock_rx_off
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------

   // Word address to register; misaligned addresses count as unmapped
   function automatic scpr_pkg::scpr_sel_t scpr_decode(input logic [11:0] addr);
      scpr_pkg::scpr_sel_t sel;
      sel = scpr_pkg::SCPR_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[11:2])
            `SCPR_IDX_SYNC_REF:   sel = scpr_pkg::SCPR_SEL_SYNC_REF;
            `SCPR_IDX_NV_SEQ:     sel = scpr_pkg::SCPR_SEL_NV_SEQ;
            `SCPR_IDX_SWING:      sel = scpr_pkg::SCPR_SEL_SWING;
            `SCPR_IDX_DRIVER:     sel = scpr_pkg::SCPR_SEL_DRIVER;
            `SCPR_IDX_CONV_POWER: sel = scpr_pkg::SCPR_SEL_CONV_POWER;
            `SCPR_IDX_ACLK:       sel = scpr_pkg::SCPR_SEL_ACLK;
            default:              sel = scpr_pkg::SCPR_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // Negative swing codes flip the clock polarity
   function automatic logic scpr_swing_inverts(input logic [4:0] code);
      return (code >= `SCPR_SWING_NEG_MIN) && (code <= `SCPR_SWING_NEG_MAX);
   endfunction

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------

   localparam logic [47:0] RST_VALS = {`SCPR_RST_ACLK, `SCPR_RST_CONV_POWER, `SCPR_RST_DRIVER,
                                       `SCPR_RST_SWING, `SCPR_RST_NV_SEQ, `SCPR_RST_SYNC_REF};
   localparam logic [47:0] WMASKS   = {`SCPR_WMASK_ACLK, `SCPR_WMASK_CONV_POWER, `SCPR_WMASK_DRIVER,
                                       `SCPR_WMASK_SWING, `SCPR_WMASK_NV_SEQ, `SCPR_WMASK_SYNC_REF};

   scpr_pkg::scpr_sel_t  sel_w;
   logic                 commit;
   logic                 wr_commit;
   scpr_pkg::scpr_byte_t reg_val [`SCPR_NUM_REGS];

   // The write lands at the edge where the master sees pready high
   assign sel_w     = scpr_decode(paddr);
   assign commit    = psel && penable && pready;
   assign wr_commit = commit && pwrite && pstrb[0];

   // One byte per register, data on lane 0 only
   for (genvar i = 0; i < `SCPR_NUM_REGS; i++) begin : g_reg
      scpr_cfg_byte #(
         .RESET_VAL (RST_VALS[i*8 +: 8]),
         .WMASK     (WMASKS[i*8 +: 8])
      ) u_byte (
         .pclk    (pclk),
         .presetn (presetn),
         .wr_en   (wr_commit && (sel_w == scpr_pkg::scpr_sel_t'(3'(i)))),
         .wr_data (pwdata[7:0]),
         .value   (reg_val[i])
      );
   end

   // ---------------------------------------------------------------
   // Control outputs
   // ---------------------------------------------------------------

   // Sync-reference receiver mode and power
   assign sync_ref_coupling_select = reg_val[0][`SCPR_BIT_COUPLING];
   assign sync_ref_receiver_off    = reg_val[0][`SCPR_BIT_SYNC_RX_OFF];

   // Start-up sequencing bits, toggled by software only
   assign nv_seq_field_a = reg_val[1][`SCPR_NV_A_HI:`SCPR_NV_A_LO];
   assign nv_seq_bit_b   = reg_val[1][`SCPR_BIT_NV_B];
   assign nv_seq_bit_c   = reg_val[1][`SCPR_BIT_NV_C];

   // Observation clock driver
   assign obs_clock_swing_code = reg_val[2][`SCPR_SWING_HI:0];
   assign obs_clock_driver_off = reg_val[3][`SCPR_BIT_DRV_OFF];

   // Converter channels and analog clock receiver
   assign converter0_off      = reg_val[4][`SCPR_BIT_CONV0_OFF];
   assign converter1_off      = reg_val[4][`SCPR_BIT_CONV1_OFF];
   assign analog_clock_rx_off = reg_val[5][`SCPR_BIT_ACLK_OFF];

   // ---------------------------------------------------------------
   // Swing polarity flag
   // ---------------------------------------------------------------

   logic inverted_q;
   logic inverted_d;

   // Registered so the pin is glitch free; lags the code by one cycle
   always_comb begin
      inverted_d = scpr_swing_inverts(obs_clock_swing_code);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inverted_q <= 1'b0;
      end else begin
         inverted_q <= inverted_d;
      end
   end

   assign obs_clock_inverted = inverted_q;

   // ---------------------------------------------------------------
   // APB answer
   // ---------------------------------------------------------------

   logic        pready_q;
   logic        pready_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // One wait state keeps prdata and pready straight from flops
   always_comb begin
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (psel && penable && !pready_q) begin
         pready_d  = 1'b1;
         pslverr_d = (sel_w == scpr_pkg::SCPR_SEL_NONE);
         if (!pwrite && (sel_w != scpr_pkg::SCPR_SEL_NONE)) begin
            prdata_d = {24'h00_0000, reg_val[sel_w]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr_sync;
   logic wr_nv;
   logic wr_swing;
   logic wr_drv;
   logic wr_pow;
   logic wr_aclk;

   // Per-register write strobes for the checks below
   assign wr_sync  = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_SYNC_REF);
   assign wr_nv    = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_NV_SEQ);
   assign wr_swing = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_SWING);
   assign wr_drv   = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_DRIVER);
   assign wr_pow   = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_CONV_POWER);
   assign wr_aclk  = wr_commit && (sel_w == scpr_pkg::SCPR_SEL_ACLK);

   sequence s_access_open;
      psel && penable && !pready;
   endsequence

   sequence s_answer_once;
      pready ##1 !pready;
   endsequence

   property p_one_wait;
      s_access_open |=> s_answer_once;
   endproperty

   a_apb_one_wait:
      assert property (p_one_wait)
      else $error("APB answer not exactly one cycle after access start");

   a_unmapped_error:
      assert property (s_access_open and (sel_w == scpr_pkg::SCPR_SEL_NONE) |=> pslverr && pready)
      else $error("Unmapped access did not answer with an error");

   a_coupling_write:
      assert property (wr_sync |=> sync_ref_coupling_select == $past(pwdata[6]))
      else $error("Coupling select did not take the written value");

   a_sync_off_hold:
      assert property (!wr_sync |=> $stable(sync_ref_receiver_off))
      else $error("Sync receiver power-down changed without a write");

   a_nv_reset_vals:
      assert property ($rose(presetn) |-> nv_seq_field_a == `SCPR_NV_A_RST && nv_seq_bit_b)
      else $error("Sequence field or bit b not at reset value");

   a_nv_bit_c:
      assert property (wr_nv |=> nv_seq_bit_c == $past(pwdata[0]))
      else $error("Sequence bit c did not take the written value");

   a_swing_invert:
      assert property (##1 obs_clock_inverted == scpr_swing_inverts($past(obs_clock_swing_code)))
      else $error("Clock inversion flag does not follow swing code");

   a_drv_reserved:
      assert property (s_access_open and (sel_w == scpr_pkg::SCPR_SEL_DRIVER) and !pwrite
                       |=> prdata[31:1] == 31'h0000_0000 && prdata[0] == obs_clock_driver_off)
      else $error("Driver register read shows reserved bits or wrong value");

   a_aclk_write:
      assert property (wr_aclk |=> analog_clock_rx_off == $past(pwdata[0]))
      else $error("Analog clock receiver bit did not take the written value");

   a_conv_indep:
      assert property (wr_pow |=> converter0_off == $past(pwdata[0]) && converter1_off == $past(pwdata[1]))
      else $error("Converter power-down bits not written independently");

   a_conv_hold:
      assert property (!wr_pow |=> $stable(converter0_off) && $stable(converter1_off))
      else $error("Converter power-down changed without a write");

   a_ready_needs_access:
      assert property (!(psel && penable) |=> !pready)
      else $error("APB ready raised without an access phase");

   a_error_needs_ready:
      assert property (pslverr |-> pready)
      else $error("APB error flag raised outside the answer cycle");

   a_rdata_idle_zero:
      assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("Read data not zero outside the answer cycle");

   a_coupling_hold:
      assert property (!wr_sync |=> $stable(sync_ref_coupling_select))
      else $error("Coupling select changed without a write");

   a_sync_off_write:
      assert property (wr_sync |=> sync_ref_receiver_off == $past(pwdata[0]))
      else $error("Sync receiver power-down did not take the written value");

   a_nv_field_write:
      assert property (wr_nv |=> nv_seq_field_a == $past(pwdata[6:4]) && nv_seq_bit_b == $past(pwdata[1]))
      else $error("Sequence field or bit b did not take the written value");

   a_swing_write:
      assert property (wr_swing |=> obs_clock_swing_code == $past(pwdata[4:0]))
      else $error("Swing code did not take the written value");

   a_drv_write:
      assert property (wr_drv |=> obs_clock_driver_off == $past(pwdata[0]))
      else $error("Driver power-down did not take the written value");

   a_aclk_reset_val:
      assert property ($rose(presetn) |-> analog_clock_rx_off)
      else $error("Analog clock receiver not powered down after reset");

   a_aclk_hold:
      assert property (!wr_aclk |=> $stable(analog_clock_rx_off))
      else $error("Analog clock receiver bit changed without a write");

   a_conv_reset_vals:
      assert property ($rose(presetn) |-> converter0_off && converter1_off)
      else $error("Converter channels not powered down after reset");

endmodule

//--- src/scpr_defs.svh
`ifndef SCPR_DEFS_SVH
`define SCPR_DEFS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define SCPR_IDX_SYNC_REF      10'h084
`define SCPR_IDX_NV_SEQ        10'h085
`define SCPR_IDX_SWING         10'h08D
`define SCPR_IDX_DRIVER        10'h08F
`define SCPR_IDX_CONV_POWER    10'h090
`define SCPR_IDX_ACLK          10'h091
`define SCPR_NUM_REGS          6

// ---------------------------------------------------------------
// Reset values and writable-bit masks
// ---------------------------------------------------------------
`define SCPR_RST_SYNC_REF      8'h00
`define SCPR_RST_NV_SEQ        8'h13
`define SCPR_RST_SWING         8'h00
`define SCPR_RST_DRIVER        8'h00
`define SCPR_RST_CONV_POWER    8'h03
`define SCPR_RST_ACLK          8'h01
`define SCPR_WMASK_SYNC_REF    8'hFF
`define SCPR_WMASK_NV_SEQ      8'h73
`define SCPR_WMASK_SWING       8'h1F
`define SCPR_WMASK_DRIVER      8'h01
`define SCPR_WMASK_CONV_POWER  8'h03
`define SCPR_WMASK_ACLK        8'hFF

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCPR_BIT_COUPLING      6
`define SCPR_BIT_SYNC_RX_OFF   0
`define SCPR_NV_A_HI           6
`define SCPR_NV_A_LO           4
`define SCPR_BIT_NV_B          1
`define SCPR_BIT_NV_C          0
`define SCPR_SWING_HI          4
`define SCPR_BIT_DRV_OFF       0
`define SCPR_BIT_CONV1_OFF     1
`define SCPR_BIT_CONV0_OFF     0
`define SCPR_BIT_ACLK_OFF      0

// ---------------------------------------------------------------
// Swing code ranges and field reset values
// ---------------------------------------------------------------
`define SCPR_SWING_NEG_MIN     5'h0A
`define SCPR_SWING_NEG_MAX     5'h13
`define SCPR_NV_A_RST          3'h1

`endif

//--- src/scpr_pkg.sv
package scpr_pkg;

   // Register selected by an APB address
   typedef enum logic [2:0] {
      SCPR_SEL_SYNC_REF   = 3'b000,
      SCPR_SEL_NV_SEQ     = 3'b001,
      SCPR_SEL_SWING      = 3'b010,
      SCPR_SEL_DRIVER     = 3'b011,
      SCPR_SEL_CONV_POWER = 3'b100,
      SCPR_SEL_ACLK       = 3'b101,
      SCPR_SEL_NONE       = 3'b110
   } scpr_sel_t;

   typedef logic [7:0] scpr_byte_t;

endpackage

//--- src/scpr_cfg_byte.sv
`timescale 1ns/100ps

// ---------------------------------------------------------------
// One configuration byte with reset value and writable mask
// ---------------------------------------------------------------
module scpr_cfg_byte #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK     = 8'hFF
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 wr_en,
   input  wire scpr_pkg::scpr_byte_t wr_data,
   output scpr_pkg::scpr_byte_t      value
);

   scpr_pkg::scpr_byte_t value_q;
   scpr_pkg::scpr_byte_t value_d;

   // Read-only bits keep their reset value, so they always read as it
   always_comb begin
      value_d = value_q;
      if (wr_en) begin
         value_d = (value_q & ~WMASK) | (wr_data & WMASK);
      end
   end

   // Storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_q <= RESET_VAL;
      end else begin
         value_q <= value_d;
      end
   end

   assign value = value_q;

endmodule

//--- tb/scpr_regs_tb_top.sv
`timescale 1ns/100ps
`include "scpr_defs.svh"

module scpr_regs_tb_top;

   // ------------------------------------------------------------
   // Signals and bench state
   // ------------------------------------------------------------
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [3:0]  pstrb   = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sync_ref_coupling_select;
   logic        sync_ref_receiver_off;
   logic [2:0]  nv_seq_field_a;
   logic        nv_seq_bit_b;
   logic        nv_seq_bit_c;
   logic [4:0]  obs_clock_swing_code;
   logic        obs_clock_inverted;
   logic        obs_clock_driver_off;
   logic        converter0_off;
   logic        converter1_off;
   logic        analog_clock_rx_off;
   int          failures        = 0;
   int          samples_checked = 0;
   int          seed            = 32'h9B49;
   logic [7:0]  model [6];

   localparam logic [7:0] RST [6] = '{`SCPR_RST_SYNC_REF, `SCPR_RST_NV_SEQ, `SCPR_RST_SWING,
                                      `SCPR_RST_DRIVER, `SCPR_RST_CONV_POWER, `SCPR_RST_ACLK};
   localparam logic [7:0] MSK [6] = '{`SCPR_WMASK_SYNC_REF, `SCPR_WMASK_NV_SEQ, `SCPR_WMASK_SWING,
                                      `SCPR_WMASK_DRIVER, `SCPR_WMASK_CONV_POWER, `SCPR_WMASK_ACLK};
   localparam logic [9:0] IDX [6] = '{`SCPR_IDX_SYNC_REF, `SCPR_IDX_NV_SEQ, `SCPR_IDX_SWING,
                                      `SCPR_IDX_DRIVER, `SCPR_IDX_CONV_POWER, `SCPR_IDX_ACLK};

   scpr_regs i_scpr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                          .prdata, .pready, .pslverr, .sync_ref_coupling_select,
                          .sync_ref_receiver_off, .nv_seq_field_a, .nv_seq_bit_b, .nv_seq_bit_c,
                          .obs_clock_swing_code, .obs_clock_inverted, .obs_clock_driver_off,
                          .converter0_off, .converter1_off, .analog_clock_rx_off);

   // Free-running 40 MHz clock
   initial begin
      forever #12.5 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [11:0] addr(input int i);
      return {IDX[i], 2'b00};
   endfunction

   // Codes 10 to 19 give a negative swing, the rest do not
   function automatic logic inv(input logic [4:0] c);
      return (c >= 5'h0A) && (c <= 5'h13);
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high, wait bounded
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         failures++;
         conclude();
      end
   endtask

   // Write; the model keeps only writable bits, and only with byte lane 0 enabled
   task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, addr(i), d, s, rd, err);
      if (s[0]) model[i] = d[7:0] & MSK[i];
   endtask

   task automatic rdchk(input int i);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, addr(i), 32'h0, 4'h0, rd, err);
      chk(rd, {24'h0, model[i]});
   endtask

   // Inverted flag lags the code by one cycle, so let two edges pass
   task automatic chk_outs();
      repeat (2) @(posedge pclk);
      #1;
      chk(sync_ref_coupling_select, model[0][6]);
      chk(sync_ref_receiver_off, model[0][0]);
      chk({nv_seq_field_a, nv_seq_bit_b}, {model[1][6:4], model[1][1]});
      chk(nv_seq_bit_c, model[1][0]);
      chk(obs_clock_swing_code, model[2][4:0]);
      chk(obs_clock_inverted, inv(model[2][4:0]));
      chk(obs_clock_driver_off, model[3][0]);
      chk({converter1_off, converter0_off}, model[4][1:0]);
      chk(analog_clock_rx_off, model[5][0]);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic        err;
      logic [4:0]  codes [5];
      int          k;
      codes = '{5'h09, 5'h0A, 5'h13, 5'h14, 5'h1F};
      foreach (model[j]) model[j] = RST[j];
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_outs();
      foreach (model[j]) rdchk(j);
      // Start-up sequencing: field a and bit b up, bit c down, then the reverse
      wr(1, 32'h0000_0012, 4'h1);
      chk_outs();
      wr(1, 32'h0000_0001, 4'h1);
      chk_outs();
      // Swing boundaries on both sides of the inverting range
      foreach (codes[j]) begin
         wr(2, {27'h7FFFFFF, codes[j]}, 4'hF);
         chk_outs();
         rdchk(2);
      end
      // Each power-down pattern, back to back with its readback
      for (k = 0; k < 4; k++) begin
         wr(4, 32'hFFFFFFFC | k, 4'h1);
         chk_outs();
         rdchk(4);
      end
      // Lane 0 disabled: write ignored
      wr(5, 32'h0, 4'hE);
      rdchk(5);
      // Unmapped and misaligned addresses answer with an error and change nothing
      apb(1'b0, 12'h218, 32'h0, 4'h0, rd, err);
      chk(rd, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 12'h211, 32'hFFFFFFFF, 4'hF, rd, err);
      chk(err, 1'b1);
      rdchk(0);
      // Random traffic over all registers
      for (k = 0; k < 60; k++) begin
         wr(int'($unsigned($random(seed)) % 6), $random(seed), 4'($random(seed)));
         if (k % 6 == 5) chk_outs();
      end
      foreach (model[j]) rdchk(j);
      // Reset in mid-run returns every field to its default
      @(posedge pclk);
      presetn <= 1'b0;
      foreach (model[j]) model[j] = RST[j];
      chk_outs();
      @(posedge pclk);
      presetn <= 1'b1;
      foreach (model[j]) rdchk(j);
      conclude();
   end

endmodule
